// ### include/timer16_pkg.sv
// Constants, types and register map of the 16-bit capture timer.
package timer16_pkg;

    // ********************
    // Widths and map
    // ********************
    localparam int unsigned ADDR_W = 6;
    localparam logic [5:0] ADDR_CTRL_A = 6'h00;
    localparam logic [5:0] ADDR_CTRL_B = 6'h01;
    localparam logic [5:0] ADDR_CNT_L = 6'h02;
    localparam logic [5:0] ADDR_CNT_H = 6'h03;
    localparam logic [5:0] ADDR_CAP_L = 6'h04;
    localparam logic [5:0] ADDR_CAP_H = 6'h05;
    localparam logic [5:0] ADDR_FLAGS = 6'h06;
    localparam logic [5:0] ADDR_IRQ_EN = 6'h07;
    localparam logic [5:0] ADDR_CMP_CS = 6'h08;

    // ********************
    // Field positions
    // ********************
    localparam int unsigned CTRLB_FILT_BIT = 7;
    localparam int unsigned CTRLB_EDGE_BIT = 6;
    localparam int unsigned CTRLB_WGM_LSB = 3;
    localparam int unsigned CTRLA_WGM_LSB = 0;
    localparam int unsigned FLAG_CAP_BIT = 5;
    localparam int unsigned FLAG_OVF_BIT = 0;
    localparam int unsigned CMP_SEL_BIT = 2;

    // ********************
    // Values and counts
    // ********************
    localparam logic [15:0] CNT_BOTTOM = 16'h0000;
    localparam logic [15:0] CNT_MAX = 16'hFFFF;
    localparam logic [15:0] TOP_8BIT = 16'h00FF;
    localparam logic [15:0] TOP_9BIT = 16'h01FF;
    localparam logic [15:0] TOP_10BIT = 16'h03FF;
    localparam logic [15:0] CNT_RST = 16'h0000;
    localparam logic [7:0] BYTE_RST = 8'h00;
    localparam logic [9:0] PRESC_RST = 10'h000;
    localparam int unsigned FILTER_SAMPLES = 4;

    typedef enum logic [2:0] {
        CS_STOP = 3'b000,
        CS_DIV1 = 3'b001,
        CS_DIV8 = 3'b010,
        CS_DIV64 = 3'b011,
        CS_DIV256 = 3'b100,
        CS_DIV1024 = 3'b101,
        CS_EXT_FALL = 3'b110,
        CS_EXT_RISE = 3'b111
    } clock_select_t;

    typedef struct packed {
        logic rd;
        logic wr;
        logic [5:0] addr;
        logic [7:0] wdata;
    } io_req_t;

    typedef struct packed {
        logic [15:0] count;
        logic count_down;
        logic [7:0] latch;
        logic [15:0] capture;
        logic [3:0] waveform_mode;
        logic [2:0] clock_select;
        logic noise_filter_enable;
        logic edge_rise;
        logic comparator_capture_select;
        logic capture_flag;
        logic overflow_flag;
        logic capture_irq_enable;
        logic overflow_irq_enable;
        logic [9:0] presc;
        logic ext_prev;
        logic trig_prev;
        logic [7:0] rdata;
        logic capture_irq;
        logic overflow_irq;
    } timer_state_t;

    typedef struct packed {
        logic [3:0] hist;
        logic level;
    } filt_state_t;

endpackage

// ### verilog/sync2.sv
// Two-stage synchroniser for asynchronous event inputs.
`timescale 1ns/100ps
module sync2 #(
    parameter int unsigned W = 1
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // Data
    input wire logic [W-1:0] async_in,
    output logic [W-1:0] sync_out
);
    import timer16_pkg::*;

    // The first stage feeds only the second; nothing else may look at it.
    logic [1:0][W-1:0] stage_q;
    logic [1:0][W-1:0] stage_d;

    always_comb begin
        stage_d = {stage_q[0], async_in}; // R15
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            stage_q <= '0;
        end else begin
            stage_q <= stage_d;
        end
    end

    assign sync_out = stage_q[1];
endmodule

// ### verilog/noise_filter.sv
// Four-sample agreement filter for the capture trigger.
`timescale 1ns/100ps
module noise_filter (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // Control and data
    input wire logic enable,
    input wire logic sample_in,
    output logic level_out
);
    import timer16_pkg::*;

    filt_state_t q;
    filt_state_t d;

    // Runs on the system clock so that the prescaler setting never changes its delay.
    // Judging the registered history, not the incoming sample, gives a five-cycle lag from sample_in to level_out.
    always_comb begin
        d = q;
        d.hist = {q.hist[2:0], sample_in}; // R17
        if (!enable) begin
            d.level = sample_in;
        end else if (q.hist == 4'hF) begin // R16
            d.level = 1'b1;
        end else if (q.hist == 4'h0) begin
            d.level = 1'b0;
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign level_out = q.level;

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    filt_agree_a: assert property ($past(enable) && $changed(q.level) // R16
        |-> $past(q.hist) == {4{q.level}})
        else $error("filter output changed without four agreeing samples");
endmodule

// ### verilog/counter16_capture.sv
// 16-bit up/down timer with shared high-byte latch and input capture.
`timescale 1ns/100ps

// How it works
// (R1) 16-bit counter counts up, down or clears
// (R2) Clock select zero stops the counter
// (R3) High byte goes through latch on low access
// (R4) Counter accessible with or without timer tick
// (R5) CPU count write beats counting
// (R6) Waveform mode sets sequence and overflow flag
// (R7) Software keeps shared-latch sequences uninterrupted
// (R8) Matching edge copies count into capture
// (R9) Capture flag sets with the copy
// (R10) Enabled flag requests irq, cleared on service
// (R11) Writing one clears capture flag
// (R12) Capture low read loads latch for high
// (R13) Capture writable only in capture-top modes
// (R14) Comparator select switches trigger source
// (R15) Trigger inputs synchronised and edge detected
// (R16) Filter changes after four agreeing samples
// (R17) Filter enable in control B, system clock
// (R18) Capture off in capture-top modes
// (R19) Own port drive on pin triggers captures
// (R20) New capture overwrites unread value
// (R21) Software flips edge and clears flag
// (R22) Avoid capture while top value changes
// (R23) One shared latch, low write loads all
// (R24) Edge select picks rising or falling
module counter16_capture (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // I/O register port
    input wire timer16_pkg::io_req_t io_req,
    output logic [7:0] io_rdata,
    // Event and count inputs
    input wire logic capture_pin,
    input wire logic comparator_output,
    input wire logic external_count_pin,
    // Interrupt service
    input wire logic capture_irq_ack,
    input wire logic overflow_irq_ack,
    output logic capture_irq,
    output logic overflow_irq
);
    import timer16_pkg::*;

    timer_state_t q;
    timer_state_t d;
    logic [2:0] sync_s;
    logic trig_raw;
    logic trig_f;
    logic timer_tick;
    logic icr_top;
    logic dual_slope;
    logic ctc_mode;
    logic [15:0] top_val;
    logic cap_evt;
    logic ovf_evt;
    logic cnt_wr;
    logic cap_clr;

    // ********************
    // Input path
    // ********************
    sync2 #(.W(3)) u_sync (
        .clk_sys(clk_sys),
        .rst(rst),
        .async_in({external_count_pin, comparator_output, capture_pin}),
        .sync_out(sync_s)
    );

    // The pin input is the pad level, so software driving the port reaches it too.
    assign trig_raw = q.comparator_capture_select ? sync_s[1] : sync_s[0]; // R14 R19

    noise_filter u_filt (
        .clk_sys(clk_sys),
        .rst(rst),
        .enable(q.noise_filter_enable), // R17
        .sample_in(trig_raw),
        .level_out(trig_f)
    );

    // ********************
    // Mode decode
    // ********************
    always_comb begin
        icr_top = 1'b0;
        dual_slope = 1'b0;
        ctc_mode = 1'b0;
        top_val = CNT_MAX;
        case (q.waveform_mode)
            4'h1, 4'h5: top_val = TOP_8BIT;
            4'h2, 4'h6: top_val = TOP_9BIT;
            4'h3, 4'h7: top_val = TOP_10BIT;
            4'h8, 4'hA, 4'hC, 4'hE: begin
                icr_top = 1'b1;
                top_val = q.capture;
            end
            default: top_val = CNT_MAX;
        endcase
        case (q.waveform_mode)
            4'h1, 4'h2, 4'h3, 4'h8, 4'h9, 4'hA, 4'hB: dual_slope = 1'b1; // R6
            4'h4, 4'hC: ctc_mode = 1'b1;
            default: dual_slope = 1'b0;
        endcase
    end

    // ********************
    // Timer tick
    // ********************
    always_comb begin
        case (clock_select_t'(q.clock_select))
            CS_STOP: timer_tick = 1'b0; // R2
            CS_DIV1: timer_tick = 1'b1;
            CS_DIV8: timer_tick = q.presc[2:0] == 3'h7;
            CS_DIV64: timer_tick = q.presc[5:0] == 6'h3F;
            CS_DIV256: timer_tick = q.presc[7:0] == 8'hFF;
            CS_DIV1024: timer_tick = q.presc == 10'h3FF;
            CS_EXT_FALL: timer_tick = q.ext_prev && !sync_s[2];
            CS_EXT_RISE: timer_tick = !q.ext_prev && sync_s[2];
            default: timer_tick = 1'b0;
        endcase
    end

    assign cnt_wr = io_req.wr && io_req.addr == ADDR_CNT_L;
    assign cap_clr = (io_req.wr && io_req.addr == ADDR_FLAGS && io_req.wdata[FLAG_CAP_BIT])
        || capture_irq_ack;
    // Capture is blocked while the capture register serves as the top value.
    assign cap_evt = !icr_top && trig_f != q.trig_prev && trig_f == q.edge_rise; // R8 R18 R24

    // ********************
    // Next state
    // ********************
    always_comb begin
        d = q;
        ovf_evt = 1'b0;
        d.presc = q.presc + 10'h001;
        d.ext_prev = sync_s[2];
        d.trig_prev = trig_f; // R15

        if (timer_tick) begin // R1
            if (dual_slope) begin
                if (!q.count_down) begin
                    if (q.count >= top_val) begin
                        d.count_down = 1'b1;
                        d.count = q.count - 16'h0001;
                    end else begin
                        d.count = q.count + 16'h0001;
                    end
                end else if (q.count == CNT_BOTTOM) begin
                    d.count_down = 1'b0;
                    d.count = q.count + 16'h0001;
                    ovf_evt = 1'b1; // R6
                end else begin
                    d.count = q.count - 16'h0001;
                end
            end else begin
                d.count_down = 1'b0;
                d.count = (q.count == top_val) ? CNT_BOTTOM : q.count + 16'h0001;
                ovf_evt = q.count == CNT_MAX || (!ctc_mode && q.count == top_val); // R6
            end
        end

        // Register writes come after counting so that they override it.
        if (io_req.wr) begin
            case (io_req.addr)
                ADDR_CTRL_A: d.waveform_mode[1:0] = io_req.wdata[CTRLA_WGM_LSB +: 2];
                ADDR_CTRL_B: begin
                    d.noise_filter_enable = io_req.wdata[CTRLB_FILT_BIT]; // R17
                    d.edge_rise = io_req.wdata[CTRLB_EDGE_BIT]; // R24
                    d.waveform_mode[3:2] = io_req.wdata[CTRLB_WGM_LSB +: 2];
                    d.clock_select = io_req.wdata[2:0]; // R2
                end
                ADDR_CNT_H, ADDR_CAP_H: d.latch = io_req.wdata; // R3 R23
                ADDR_CNT_L: d.count = {q.latch, io_req.wdata}; // R4 R5 R23
                ADDR_CAP_L: begin
                    if (icr_top) begin
                        d.capture = {q.latch, io_req.wdata}; // R13
                    end
                end
                ADDR_FLAGS: begin
                    if (io_req.wdata[FLAG_OVF_BIT]) begin
                        d.overflow_flag = 1'b0;
                    end
                end
                ADDR_IRQ_EN: begin
                    d.capture_irq_enable = io_req.wdata[FLAG_CAP_BIT];
                    d.overflow_irq_enable = io_req.wdata[FLAG_OVF_BIT];
                end
                ADDR_CMP_CS: d.comparator_capture_select = io_req.wdata[CMP_SEL_BIT]; // R14
                default: d.latch = q.latch;
            endcase
        end

        if (cap_clr) begin
            d.capture_flag = 1'b0; // R10 R11
        end
        if (overflow_irq_ack) begin
            d.overflow_flag = 1'b0;
        end

        // Events are applied last: a set in the clearing cycle is never lost.
        if (ovf_evt) begin
            d.overflow_flag = 1'b1;
        end
        if (cap_evt) begin
            d.capture = q.count; // R8 R20
            d.capture_flag = 1'b1; // R9
        end

        d.rdata = BYTE_RST;
        if (io_req.rd) begin
            case (io_req.addr)
                ADDR_CTRL_A: d.rdata = {6'h00, q.waveform_mode[1:0]};
                ADDR_CTRL_B: d.rdata = {q.noise_filter_enable, q.edge_rise, 1'b0,
                    q.waveform_mode[3:2], q.clock_select};
                ADDR_CNT_L: begin
                    d.rdata = q.count[7:0];
                    d.latch = q.count[15:8]; // R3
                end
                ADDR_CAP_L: begin
                    d.rdata = q.capture[7:0];
                    d.latch = q.capture[15:8]; // R12
                end
                ADDR_CNT_H, ADDR_CAP_H: d.rdata = q.latch; // R12
                ADDR_FLAGS: d.rdata = {2'b00, q.capture_flag, 4'h0, q.overflow_flag};
                ADDR_IRQ_EN: d.rdata = {2'b00, q.capture_irq_enable, 4'h0,
                    q.overflow_irq_enable};
                ADDR_CMP_CS: d.rdata = {5'h00, q.comparator_capture_select, 2'b00};
                default: d.rdata = BYTE_RST;
            endcase
        end

        d.capture_irq = q.capture_flag && q.capture_irq_enable; // R10
        d.overflow_irq = q.overflow_flag && q.overflow_irq_enable; // R6
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign io_rdata = q.rdata;
    assign capture_irq = q.capture_irq;
    assign overflow_irq = q.overflow_irq;

    // ********************
    // Checks
    // ********************
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    sequence cap_low_read;
        io_req.rd && io_req.addr == ADDR_CAP_L;
    endsequence

    sequence cap_high_read;
        io_req.rd && io_req.addr == ADDR_CAP_H && !io_req.wr;
    endsequence

    stop_hold_a: assert property (q.clock_select == 3'h0 && !cnt_wr |=> q.count == $past(q.count)) // R2
        else $error("counter moved with no clock selected");
    count_write_a: assert property (cnt_wr |=> q.count == {$past(q.latch), $past(io_req.wdata)}) // R5
        else $error("count write lost or mixed with counting");
    count_up_a: assert property (q.waveform_mode == 4'h0 && timer_tick && !cnt_wr // R1
        |=> q.count == $past(q.count) + 16'h0001)
        else $error("normal mode did not increment");
    cap_copy_a: assert property (cap_evt |=> q.capture == $past(q.count) && q.capture_flag) // R9
        else $error("capture copy and flag not in the same cycle");
    flag_clear_a: assert property (cap_clr && !cap_evt |=> !q.capture_flag) // R11
        else $error("capture flag not cleared");
    set_wins_a: assert property (cap_clr && cap_evt |=> q.capture_flag) // R11
        else $error("capture lost to a clear");
    cap_block_a: assert property (icr_top && !(io_req.wr && io_req.addr == ADDR_CAP_L) // R18
        |=> q.capture == $past(q.capture))
        else $error("capture fired in capture-top mode");
    latch_pair_a: assert property (cap_low_read ##1 cap_high_read // R12
        |=> io_rdata == $past(q.capture[15:8], 2))
        else $error("capture high byte not from latch");
    irq_req_a: assert property (q.capture_flag && q.capture_irq_enable |=> capture_irq) // R10
        else $error("capture irq not requested");
endmodule

// ### testbench/event_source.sv
// Behavioural model of the capture pin driver and the comparator output.
`timescale 1ns/100ps
module event_source (
    // Clock
    input wire logic clk_sys,
    // Requested levels and lag in cycles
    input wire logic pin_req,
    input wire logic cmp_req,
    input wire logic [3:0] lag,
    // Levels seen by the timer
    output logic capture_pin,
    output logic comparator_output
);
    logic [15:0] pin_hist = 16'h0000;
    logic [15:0] cmp_hist = 16'h0000;

    // A slow source is a lag of whole cycles; both lines are always driven, never released.
    always @(posedge clk_sys) begin
        pin_hist <= {pin_hist[14:0], pin_req};
        cmp_hist <= {cmp_hist[14:0], cmp_req};
    end

    assign capture_pin = (lag == 4'h0) ? pin_req : pin_hist[lag - 4'h1];
    assign comparator_output = (lag == 4'h0) ? cmp_req : cmp_hist[lag - 4'h1];
endmodule

// ### testbench/testbench.sv
// Self-checking bench for the 16-bit capture timer.
`timescale 1ns/100ps
module testbench;
    import timer16_pkg::*;

    logic clk_sys;
    logic rst;
    io_req_t io_req;
    logic [7:0] io_rdata;
    logic pin_req;
    logic cmp_req;
    logic [3:0] lag;
    logic capture_pin;
    logic comparator_output;
    logic capture_irq_ack;
    logic overflow_irq_ack;
    logic external_count_pin;
    logic capture_irq;
    logic overflow_irq;
    int num_errors = 0;
    int n_compared = 0;

    counter16_capture u_dut (
        .clk_sys(clk_sys), .rst(rst), .io_req(io_req), .io_rdata(io_rdata),
        .capture_pin(capture_pin), .comparator_output(comparator_output),
        .external_count_pin(external_count_pin), .capture_irq_ack(capture_irq_ack),
        .overflow_irq_ack(overflow_irq_ack), .capture_irq(capture_irq),
        .overflow_irq(overflow_irq)
    );

    event_source u_src (
        .clk_sys(clk_sys), .pin_req(pin_req), .cmp_req(cmp_req), .lag(lag),
        .capture_pin(capture_pin), .comparator_output(comparator_output)
    );

    // ********************
    // Shared tasks
    // ********************
    task automatic conclude;
        $display("compared %0d, errors %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task automatic check8(input string name, input logic [7:0] exp, input logic [7:0] got);
        n_compared++;
        if (got !== exp) begin
            $display("wrong value %s expected %h seen %h", name, exp, got);
            num_errors++;
        end
    endtask

    task automatic check1(input string name, input logic exp, input logic got);
        n_compared++;
        if (got !== exp) begin
            $display("wrong value %s expected %b seen %b", name, exp, got);
            num_errors++;
        end
    endtask

    task automatic idle(input int n);
        repeat (n) @(negedge clk_sys);
    endtask

    // Strobes are one-cycle pulses, then a quiet cycle before the next access.
    task automatic reg_wr(input logic [5:0] a, input logic [7:0] d);
        @(negedge clk_sys);
        io_req <= '{rd: 1'b0, wr: 1'b1, addr: a, wdata: d};
        @(negedge clk_sys);
        io_req <= '0;
    endtask

    task automatic reg_rd(input logic [5:0] a, output logic [7:0] d);
        @(negedge clk_sys);
        io_req <= '{rd: 1'b1, wr: 1'b0, addr: a, wdata: 8'h00};
        @(negedge clk_sys);
        d = io_rdata;
        io_req <= '0;
    endtask

    task automatic rd_chk(input string name, input logic [5:0] a, input logic [7:0] exp);
        logic [7:0] d;
        reg_rd(a, d);
        check8(name, exp, d);
    endtask

    // Low then high on consecutive cycles, so the high byte can only come from the latch.
    task automatic rd_pair(input logic [5:0] a, output logic [7:0] lo, output logic [7:0] hi);
        @(negedge clk_sys);
        io_req <= '{rd: 1'b1, wr: 1'b0, addr: a, wdata: 8'h00};
        @(negedge clk_sys);
        lo = io_rdata;
        io_req <= '{rd: 1'b1, wr: 1'b0, addr: a + 6'h01, wdata: 8'h00};
        @(negedge clk_sys);
        hi = io_rdata;
        io_req <= '0;
    endtask

    task automatic ext_pulses(input int n);
        repeat (n) begin
            external_count_pin = 1'b1;
            idle(4);
            external_count_pin = 1'b0;
            idle(4);
        end
    endtask

    // ********************
    // Scenarios
    // ********************
    task automatic t_count_access;
        rd_chk("count low at reset", ADDR_CNT_L, 8'h00);
        rd_chk("unmapped read", 6'h3F, 8'h00);
        reg_wr(ADDR_CNT_H, 8'h01);
        reg_wr(ADDR_CNT_L, 8'hFF);
        reg_wr(ADDR_CNT_H, 8'h77);
        rd_chk("count low", ADDR_CNT_L, 8'hFF);
        rd_chk("count high via latch", ADDR_CNT_H, 8'h01);
    endtask

    task automatic t_count_run;
        logic [7:0] a;
        logic [7:0] b;
        reg_wr(ADDR_CTRL_B, 8'h01);
        reg_rd(ADDR_CNT_L, a);
        reg_rd(ADDR_CNT_L, b);
        check8("count step", a + 8'h02, b);
        reg_wr(ADDR_CTRL_B, 8'h00);
        reg_rd(ADDR_CNT_L, a);
        idle(5);
        reg_rd(ADDR_CNT_L, b);
        check8("stopped count", a, b);
    endtask

    task automatic t_capture;
        reg_wr(ADDR_CNT_H, 8'h12);
        reg_wr(ADDR_CNT_L, 8'h34);
        reg_wr(ADDR_CTRL_B, 8'h40);
        pin_req = 1'b1;
        idle(12);
        rd_chk("flag after rise", ADDR_FLAGS, 8'h20);
        rd_chk("capture low", ADDR_CAP_L, 8'h34);
        rd_chk("capture high", ADDR_CAP_H, 8'h12);
        reg_wr(ADDR_CNT_H, 8'h56);
        reg_wr(ADDR_CNT_L, 8'h78);
        reg_wr(ADDR_CTRL_B, 8'h00);
        pin_req = 1'b0;
        idle(12);
        rd_chk("overwritten low", ADDR_CAP_L, 8'h78);
        rd_chk("overwritten high", ADDR_CAP_H, 8'h56);
        reg_wr(ADDR_FLAGS, 8'h00);
        rd_chk("flag kept on zero", ADDR_FLAGS, 8'h20);
        reg_wr(ADDR_FLAGS, 8'h20);
        rd_chk("flag cleared", ADDR_FLAGS, 8'h00);
    endtask

    task automatic t_irq;
        reg_wr(ADDR_IRQ_EN, 8'h20);
        reg_wr(ADDR_CTRL_B, 8'h40);
        pin_req = 1'b1;
        idle(12);
        check1("capture irq", 1'b1, capture_irq);
        capture_irq_ack <= 1'b1;
        idle(1);
        capture_irq_ack <= 1'b0;
        idle(3);
        check1("irq after service", 1'b0, capture_irq);
        rd_chk("flag after service", ADDR_FLAGS, 8'h00);
        reg_wr(ADDR_IRQ_EN, 8'h00);
    endtask

    task automatic t_comparator;
        reg_wr(ADDR_CMP_CS, 8'h04);
        idle(8);
        reg_wr(ADDR_FLAGS, 8'h20);
        pin_req = 1'b0;
        idle(8);
        pin_req = 1'b1;
        idle(12);
        rd_chk("pin ignored", ADDR_FLAGS, 8'h00);
        cmp_req = 1'b1;
        idle(12);
        rd_chk("comparator capture", ADDR_FLAGS, 8'h20);
        reg_wr(ADDR_CMP_CS, 8'h00);
        reg_wr(ADDR_FLAGS, 8'h20);
    endtask

    task automatic t_filter;
        lag = 4'h3;
        pin_req = 1'b0;
        reg_wr(ADDR_CNT_H, 8'h0A);
        reg_wr(ADDR_CNT_L, 8'hBC);
        reg_wr(ADDR_CTRL_B, 8'hC0);
        idle(14);
        reg_wr(ADDR_FLAGS, 8'h20);
        pin_req = 1'b1;
        idle(3);
        pin_req = 1'b0;
        idle(16);
        rd_chk("short pulse", ADDR_FLAGS, 8'h00);
        pin_req = 1'b1;
        idle(18);
        rd_chk("filtered flag", ADDR_FLAGS, 8'h20);
        rd_chk("filtered capture", ADDR_CAP_L, 8'hBC);
        lag = 4'h0;
    endtask

    task automatic t_capture_top;
        logic [7:0] lo;
        logic [7:0] hi;
        reg_wr(ADDR_CTRL_B, 8'h00);
        reg_wr(ADDR_CAP_H, 8'h11);
        reg_wr(ADDR_CAP_L, 8'h22);
        rd_chk("capture write refused", ADDR_CAP_L, 8'hBC);
        reg_wr(ADDR_CTRL_A, 8'h00);
        reg_wr(ADDR_CTRL_B, 8'h58);
        reg_wr(ADDR_CAP_H, 8'hAB);
        reg_wr(ADDR_CAP_L, 8'hCD);
        reg_wr(ADDR_CNT_H, 8'h55);
        rd_pair(ADDR_CAP_L, lo, hi);
        check8("top low", 8'hCD, lo);
        check8("top high", 8'hAB, hi);
        reg_wr(ADDR_FLAGS, 8'h20);
        pin_req = 1'b0;
        idle(10);
        pin_req = 1'b1;
        idle(12);
        rd_chk("no capture in top mode", ADDR_FLAGS, 8'h00);
    endtask

    task automatic t_overflow;
        reg_wr(ADDR_IRQ_EN, 8'h01);
        reg_wr(ADDR_CTRL_B, 8'h01);
        reg_wr(ADDR_CNT_H, 8'hFF);
        reg_wr(ADDR_CNT_L, 8'hF0);
        idle(24);
        check1("overflow irq", 1'b1, overflow_irq);
        rd_chk("overflow flag", ADDR_FLAGS, 8'h01);
        overflow_irq_ack <= 1'b1;
        idle(1);
        overflow_irq_ack <= 1'b0;
        idle(3);
        check1("overflow irq after service", 1'b0, overflow_irq);
        rd_chk("overflow flag after service", ADDR_FLAGS, 8'h00);
        reg_wr(ADDR_CTRL_B, 8'h07);
        reg_wr(ADDR_CTRL_A, 8'h01);
        reg_wr(ADDR_CNT_H, 8'h00);
        reg_wr(ADDR_CNT_L, 8'hFE);
        ext_pulses(3);
        rd_chk("dual slope turn", ADDR_CNT_L, 8'hFD);
        reg_wr(ADDR_CNT_L, 8'h01);
        ext_pulses(2);
        rd_chk("overflow at bottom", ADDR_FLAGS, 8'h01);
        reg_wr(ADDR_FLAGS, 8'h01);
        rd_chk("overflow cleared", ADDR_FLAGS, 8'h00);
    endtask

    // ********************
    // Clock, reset and sequence
    // ********************
    initial begin
        clk_sys = 1'b0;
        forever #4 clk_sys = ~clk_sys;
    end

    initial begin
        #200000;
        num_errors++;
        conclude();
    end

    initial begin
        rst = 1'b1;
        io_req = '0;
        pin_req = 1'b0;
        cmp_req = 1'b0;
        lag = 4'h0;
        capture_irq_ack = 1'b0;
        overflow_irq_ack = 1'b0;
        external_count_pin = 1'b0;
        repeat (12) @(negedge clk_sys);
        rst = 1'b0;
        t_count_access();
        t_count_run();
        t_capture();
        t_irq();
        t_comparator();
        t_filter();
        t_capture_top();
        t_overflow();
        conclude();
    end
endmodule
